// ### rtl/sync_route_pkg.sv
// Constants and types for the sync polarity and routing block
package sync_route_pkg;

    // ========================================================================
    // Bus geometry
    localparam int PADDR_W = 8;
    localparam int PDATA_W = 32;
    localparam int REG_W = 8;

    // ========================================================================
    // Register byte offsets
    localparam logic [7:0] OFS_IN_CTL = 8'h00;
    localparam logic [7:0] OFS_OUT_CTL = 8'h04;
    localparam logic [7:0] OFS_SRC_SEL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;

    // ========================================================================
    // Reset values
    localparam logic [7:0] RST_IN_CTL = 8'h00;
    localparam logic [7:0] RST_OUT_CTL = 8'h00;
    localparam logic [7:0] RST_SRC_SEL = 8'h00;

    // ========================================================================
    // Input connection register fields
    localparam int IN_MODE_LSB = 6;
    localparam int IN_CONNECT_BIT = 5;
    localparam int IN_CAPTURE_BIT = 4;
    localparam int IN_SPARE_H_INV_BIT = 3;
    localparam int IN_SPARE_V_INV_BIT = 2;
    localparam int IN_H_INV_BIT = 1;
    localparam int IN_V_INV_BIT = 0;

    // ========================================================================
    // Output control register fields
    localparam int OUT_H_OE_BIT = 7;
    localparam int OUT_V_OE_BIT = 6;
    localparam int OUT_CL_OE_BIT = 5;
    localparam int OUT_BL_OE_BIT = 4;
    localparam int OUT_H_INV_BIT = 3;
    localparam int OUT_V_INV_BIT = 2;
    localparam int OUT_CL_INV_BIT = 1;
    localparam int OUT_BL_INV_BIT = 0;

    // ========================================================================
    // Output source select register fields
    localparam int SRC_BANK_BIT = 7;
    localparam int SRC_ISG_BIT = 6;
    localparam int SRC_H_MODE_LSB = 4;
    localparam int SRC_V_MODE_LSB = 2;
    localparam int SRC_CL_MODE_LSB = 0;

    // ========================================================================
    // Status register fields
    localparam int STAT_IHI_BIT = 1;
    localparam int STAT_IVI_BIT = 0;

    // ========================================================================
    // Shared pin indices
    localparam int PIN_H = 0;
    localparam int PIN_V = 1;
    localparam int PIN_CL = 2;
    localparam int PIN_BL = 3;
    localparam int PIN_N = 4;

    typedef enum logic [1:0] {
        IN_SPARE,
        IN_SYNC_ON_GREEN,
        IN_COMPOSITE,
        IN_SEPARATE
    } in_mode_t;

endpackage : sync_route_pkg

// ### rtl/sync_signal_polarity_routing.sv
// Sync input conditioning, output routing and polarity control
//
// Contract
// R01 - Spare horizontal input inverted when bit 3 set
// R02 - Spare vertical input inverted when bit 2 set
// R03 - One bit inverts horizontal and composite inputs
// R04 - Vertical input inverted when bit 0 set
// R05 - Output control clears on reset and standby
// R06 - Source select clears on reset and standby
// R07 - Horizontal enable hands pin to horizontal output
// R08 - Vertical enable hands pin to vertical output
// R09 - Clamp enable hands pin to clamp output
// R10 - Blank enable hands pin to blanking output
// R11 - Disabled pins follow port and timer drive
// R12 - Enables never touch timer input paths
// R13 - Horizontal output inverted when bit 3 set
// R14 - Vertical output inverted when bit 2 set
// R15 - Selected clamp inverted when bit 1 set
// R16 - Blanking output inverted when bit 0 set
// R17 - Bank bit picks timer A or B window
// R18 - Timer banks reachable only with host iface off
// R19 - Internal select takes generated sync sources
// R20 - Horizontal mode picks plain, 2fH or clamp
// R21 - Vertical mode picks modified vertical variants
// R22 - Clamp mode picks first three clamps
// R23 - Input mode picks conditioned sync sources
// R24 - Clamp-derived horizontal uses first clamp
// R25 - Reserved mode codes give low signal
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps

module sync_signal_polarity_routing (
    input logic CLK_SYS_I,
    input logic ARST_N_I,
    input logic STANDBY_I,
    input logic PSEL_I,
    input logic PENABLE_I,
    input logic PWRITE_I,
    input logic [sync_route_pkg::PADDR_W-1:0] PADDR_I,
    input logic [sync_route_pkg::PDATA_W-1:0] PWDATA_I,
    input logic [3:0] PSTRB_I,
    output logic PREADY_O,
    output logic [sync_route_pkg::PDATA_W-1:0] PRDATA_O,
    output logic PSLVERR_O,
    input logic HORIZ_SYNC_IN_PIN_I,
    input logic COMPOSITE_SYNC_IN_PIN_I,
    input logic VERT_SYNC_IN_PIN_I,
    input logic SPARE_HORIZ_IN_PIN_I,
    input logic SPARE_VERT_IN_PIN_I,
    input logic SEPARATED_VERT_I,
    input logic HORIZ_2FH_MOD_I,
    input logic [3:1] VERT_VARIANT_I,
    input logic GENERATED_HORIZ_SYNC_I,
    input logic GENERATED_VERT_SYNC_I,
    input logic [3:0] CLAMP_VARIANT_I,
    input logic BLANK_I,
    input logic HOST_IFACE_ENABLE_I,
    input logic [sync_route_pkg::PIN_N-1:0] ALT_OUT_I,
    input logic [sync_route_pkg::PIN_N-1:0] ALT_OE_N_I,
    output logic [sync_route_pkg::PIN_N-1:0] PIN_OUT_O,
    output logic [sync_route_pkg::PIN_N-1:0] PIN_OE_N_O,
    output logic CONDITIONED_HORIZ_IN_O,
    output logic CONDITIONED_VERT_IN_O,
    output logic SYNC_TIMER_CONNECT_O,
    output logic TIMER_BANK_SELECT_O,
    output logic TIMER_BANK_ACCESS_O
);
    import sync_route_pkg::*;

    // ========================================================================
    // Mode selection helper
    function automatic logic mode_pick(input logic [1:0] code,
                                       input logic [3:0] src);
        mode_pick = src[code];
    endfunction : mode_pick

    // ========================================================================
    // Registers
    logic [REG_W-1:0] in_ctl_ff;
    logic [REG_W-1:0] out_ctl_ff;
    logic [REG_W-1:0] src_sel_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [PDATA_W-1:0] prdata_ff;
    logic [PIN_N-1:0] pin_out_ff;
    logic [PIN_N-1:0] pin_oe_n_ff;
    logic ihi_ff;
    logic ivi_ff;
    logic bank_acc_ff;

    // ========================================================================
    // Bus decode
    wire setup_w = PSEL_I & ~PENABLE_I;
    wire access_w = PSEL_I & PENABLE_I & pready_ff;
    wire hit_in_w = (PADDR_I == OFS_IN_CTL);
    wire hit_out_w = (PADDR_I == OFS_OUT_CTL);
    wire hit_src_w = (PADDR_I == OFS_SRC_SEL);
    wire hit_stat_w = (PADDR_I == OFS_STATUS);
    wire mapped_w = hit_in_w | hit_out_w | hit_src_w | hit_stat_w;
    // Status is read-only, so a write to it is flagged as an error
    wire bad_w = ~mapped_w | (hit_stat_w & PWRITE_I);
    wire wr_w = access_w & PWRITE_I & ~pslverr_ff & PSTRB_I[0];
    wire [REG_W-1:0] wbyte_w = PWDATA_I[REG_W-1:0];
    wire [REG_W-1:0] status_w = {6'h00, ihi_ff, ivi_ff};
    wire [REG_W-1:0] rd_byte_w = hit_in_w ? in_ctl_ff :
                                 hit_out_w ? out_ctl_ff :
                                 hit_src_w ? src_sel_ff :
                                 hit_stat_w ? status_w : 8'h00;

    // ========================================================================
    // Standby wins over a write in the same cycle
    wire [REG_W-1:0] nxt_in_ctl = STANDBY_I ? RST_IN_CTL :
        (wr_w & hit_in_w) ? wbyte_w : in_ctl_ff;
    wire [REG_W-1:0] nxt_out_ctl = STANDBY_I ? RST_OUT_CTL :   // [R05]
        (wr_w & hit_out_w) ? wbyte_w : out_ctl_ff;
    wire [REG_W-1:0] nxt_src_sel = STANDBY_I ? RST_SRC_SEL :   // [R06]
        (wr_w & hit_src_w) ? wbyte_w : src_sel_ff;

    // ========================================================================
    // Input conditioning
    wire h_inv_w = in_ctl_ff[IN_H_INV_BIT];
    wire v_in_w = VERT_SYNC_IN_PIN_I ^ in_ctl_ff[IN_V_INV_BIT];       // [R04]
    wire h_in_w = HORIZ_SYNC_IN_PIN_I ^ h_inv_w;                      // [R03]
    wire c_in_w = COMPOSITE_SYNC_IN_PIN_I ^ h_inv_w;                  // [R03]
    wire sh_in_w = SPARE_HORIZ_IN_PIN_I ^ in_ctl_ff[IN_SPARE_H_INV_BIT]; // [R01]
    wire sv_in_w = SPARE_VERT_IN_PIN_I ^ in_ctl_ff[IN_SPARE_V_INV_BIT];  // [R02]
    wire [1:0] in_mode_w = in_ctl_ff[IN_MODE_LSB +: 2];
    wire nxt_ihi = mode_pick(in_mode_w, {h_in_w, h_in_w, c_in_w, sh_in_w}); // [R23]
    wire nxt_ivi = mode_pick(in_mode_w,
        {v_in_w, SEPARATED_VERT_I, SEPARATED_VERT_I, sv_in_w});         // [R23]

    // ========================================================================
    // Output source selection
    wire isg_w = src_sel_ff[SRC_ISG_BIT];
    wire [1:0] h_mode_w = src_sel_ff[SRC_H_MODE_LSB +: 2];
    wire [1:0] v_mode_w = src_sel_ff[SRC_V_MODE_LSB +: 2];
    wire [1:0] cl_mode_w = src_sel_ff[SRC_CL_MODE_LSB +: 2];
    // Reserved codes read a constant low so the pin stays deterministic
    wire iho_ext_w = mode_pick(h_mode_w,
        {1'b0, CLAMP_VARIANT_I[0], HORIZ_2FH_MOD_I, ihi_ff}); // [R20] [R24] [R25]
    wire ivo_ext_w = mode_pick(v_mode_w, {VERT_VARIANT_I, ivi_ff});     // [R21]
    wire clo_ext_w = mode_pick(cl_mode_w,
        {1'b0, CLAMP_VARIANT_I[2:0]});                          // [R22] [R25]
    wire iho_gen_w = (h_mode_w == 2'b00) & GENERATED_HORIZ_SYNC_I; // [R19] [R25]
    wire ivo_gen_w = (v_mode_w == 2'b00) & GENERATED_VERT_SYNC_I;  // [R19] [R25]
    wire clo_gen_w = (cl_mode_w == 2'b00) & CLAMP_VARIANT_I[3];    // [R19] [R25]
    wire iho_w = isg_w ? iho_gen_w : iho_ext_w;                     // [R19]
    wire ivo_w = isg_w ? ivo_gen_w : ivo_ext_w;                     // [R19]
    wire clo_w = isg_w ? clo_gen_w : clo_ext_w;                     // [R19]

    // ========================================================================
    // Output polarity and pin hand-over
    wire [PIN_N-1:0] sync_sig_w = {
        BLANK_I ^ out_ctl_ff[OUT_BL_INV_BIT],                      // [R16]
        clo_w ^ out_ctl_ff[OUT_CL_INV_BIT],                        // [R15]
        ivo_w ^ out_ctl_ff[OUT_V_INV_BIT],                         // [R14]
        iho_w ^ out_ctl_ff[OUT_H_INV_BIT]};                        // [R13]
    wire [PIN_N-1:0] pin_en_w = {out_ctl_ff[OUT_BL_OE_BIT],
        out_ctl_ff[OUT_CL_OE_BIT], out_ctl_ff[OUT_V_OE_BIT],
        out_ctl_ff[OUT_H_OE_BIT]};
    // Disabled pins follow the port and timer logic untouched
    wire [PIN_N-1:0] nxt_pin_out =
        (pin_en_w & sync_sig_w) | (~pin_en_w & ALT_OUT_I); // [R07] [R08] [R09] [R10] [R11]
    wire [PIN_N-1:0] nxt_pin_oe_n = ~pin_en_w & ALT_OE_N_I; // [R07] [R08] [R09] [R10] [R11]

    // ========================================================================
    // Register file
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            in_ctl_ff <= RST_IN_CTL;
            out_ctl_ff <= RST_OUT_CTL;
            src_sel_ff <= RST_SRC_SEL;
        end else begin
            in_ctl_ff <= nxt_in_ctl;
            out_ctl_ff <= nxt_out_ctl;
            src_sel_ff <= nxt_src_sel;
        end
    end

    // ========================================================================
    // Bus answer: no wait state, data captured in the setup cycle
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            pready_ff <= setup_w;
            pslverr_ff <= setup_w & bad_w;
            if (setup_w) begin
                prdata_ff <= PWRITE_I ? '0 : {24'h000000, rd_byte_w};
            end
        end
    end

    // ========================================================================
    // Signal path flops
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ihi_ff <= 1'b0;
            ivi_ff <= 1'b0;
            pin_out_ff <= '0;
            pin_oe_n_ff <= '1;
            bank_acc_ff <= 1'b0;
        end else begin
            ihi_ff <= nxt_ihi;
            ivi_ff <= nxt_ivi;
            pin_out_ff <= nxt_pin_out;
            pin_oe_n_ff <= nxt_pin_oe_n;
            bank_acc_ff <= ~HOST_IFACE_ENABLE_I;                    // [R18]
        end
    end

    // ========================================================================
    // Outputs
    assign PREADY_O = pready_ff;
    assign PSLVERR_O = pslverr_ff;
    assign PRDATA_O = prdata_ff;
    assign PIN_OUT_O = pin_out_ff;
    assign PIN_OE_N_O = pin_oe_n_ff;
    assign CONDITIONED_HORIZ_IN_O = ihi_ff;
    assign CONDITIONED_VERT_IN_O = ivi_ff;
    // Timer input routing changes only through the connect bit
    assign SYNC_TIMER_CONNECT_O = in_ctl_ff[IN_CONNECT_BIT];        // [R12]
    assign TIMER_BANK_SELECT_O = src_sel_ff[SRC_BANK_BIT];          // [R17]
    assign TIMER_BANK_ACCESS_O = bank_acc_ff;                       // [R18]

    // ========================================================================
    // Assertions
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!ARST_N_I);

    sequence bus_setup_s;
        PSEL_I && !PENABLE_I;
    endsequence

    sequence bus_access_s;
        PSEL_I && PENABLE_I && PREADY_O;
    endsequence

    sequence out_write_s;
        bus_access_s ##0 (PWRITE_I && hit_out_w && !PSLVERR_O
            && PSTRB_I[0] && !STANDBY_I);
    endsequence

    sequence src_write_s;
        bus_access_s ##0 (PWRITE_I && hit_src_w && !PSLVERR_O
            && PSTRB_I[0] && !STANDBY_I);
    endsequence

    spare_h_in_a: assert property ( // [R01]
        (in_mode_w == 2'b00) |=> CONDITIONED_HORIZ_IN_O ==
        ($past(SPARE_HORIZ_IN_PIN_I) ^ $past(in_ctl_ff[IN_SPARE_H_INV_BIT])))
        else $error("spare horizontal input polarity wrong");

    spare_v_in_a: assert property ( // [R02]
        (in_mode_w == 2'b00) |=> CONDITIONED_VERT_IN_O ==
        ($past(SPARE_VERT_IN_PIN_I) ^ $past(in_ctl_ff[IN_SPARE_V_INV_BIT])))
        else $error("spare vertical input polarity wrong");

    comp_in_a: assert property ( // [R03]
        (in_mode_w == 2'b01) |=> CONDITIONED_HORIZ_IN_O ==
        ($past(COMPOSITE_SYNC_IN_PIN_I) ^ $past(in_ctl_ff[IN_H_INV_BIT])))
        else $error("composite input polarity wrong");

    vert_in_a: assert property ( // [R04]
        (in_mode_w == 2'b11) |=> CONDITIONED_VERT_IN_O ==
        ($past(VERT_SYNC_IN_PIN_I) ^ $past(in_ctl_ff[IN_V_INV_BIT])))
        else $error("vertical input polarity wrong");

    out_standby_a: assert property ( // [R05]
        STANDBY_I |=> (out_ctl_ff == RST_OUT_CTL))
        else $error("output control not cleared by standby");

    src_standby_a: assert property ( // [R06]
        STANDBY_I |=> (src_sel_ff == RST_SRC_SEL))
        else $error("source select not cleared by standby");

    out_write_a: assert property ( // [R05]
        out_write_s |=> (out_ctl_ff == $past(PWDATA_I[REG_W-1:0])))
        else $error("output control write lost");

    bus_answer_a: assert property (
        bus_setup_s |=> PREADY_O ##1 !PREADY_O)
        else $error("bus answer timing wrong");

    horiz_pin_a: assert property ( // [R07]
        out_ctl_ff[OUT_H_OE_BIT] |=> !PIN_OE_N_O[PIN_H] &&
        PIN_OUT_O[PIN_H] == $past(iho_w ^ out_ctl_ff[OUT_H_INV_BIT]))
        else $error("horizontal sync pin hand-over wrong");

    clamp_pin_a: assert property ( // [R15]
        out_ctl_ff[OUT_CL_OE_BIT] && !isg_w && cl_mode_w == 2'b01
        |=> PIN_OUT_O[PIN_CL] ==
        ($past(CLAMP_VARIANT_I[1]) ^ $past(out_ctl_ff[OUT_CL_INV_BIT])))
        else $error("clamp pin polarity wrong");

    blank_alt_a: assert property ( // [R11]
        !out_ctl_ff[OUT_BL_OE_BIT] |=>
        PIN_OUT_O[PIN_BL] == $past(ALT_OUT_I[PIN_BL]) &&
        PIN_OE_N_O[PIN_BL] == $past(ALT_OE_N_I[PIN_BL]))
        else $error("disabled blanking pin not following port");

    internal_h_a: assert property ( // [R19]
        out_ctl_ff[OUT_H_OE_BIT] && isg_w && h_mode_w == 2'b00 |=>
        PIN_OUT_O[PIN_H] == ($past(GENERATED_HORIZ_SYNC_I)
        ^ $past(out_ctl_ff[OUT_H_INV_BIT])))
        else $error("generated horizontal sync not routed");

    reserved_low_a: assert property ( // [R25]
        out_ctl_ff[OUT_V_OE_BIT] && isg_w && v_mode_w != 2'b00 |=>
        PIN_OUT_O[PIN_V] == $past(out_ctl_ff[OUT_V_INV_BIT]))
        else $error("reserved vertical code not low");

    bank_gate_a: assert property ( // [R18]
        HOST_IFACE_ENABLE_I |=> !TIMER_BANK_ACCESS_O)
        else $error("timer banks open while host iface on");

    vert_pin_a: assert property ( // [R08]
        out_ctl_ff[OUT_V_OE_BIT] |=> !PIN_OE_N_O[PIN_V] &&
        PIN_OUT_O[PIN_V] == $past(ivo_w ^ out_ctl_ff[OUT_V_INV_BIT]))
        else $error("vertical sync pin hand-over wrong");

    clamp_hand_a: assert property ( // [R09]
        out_ctl_ff[OUT_CL_OE_BIT] |=> !PIN_OE_N_O[PIN_CL] &&
        PIN_OUT_O[PIN_CL] == $past(clo_w ^ out_ctl_ff[OUT_CL_INV_BIT]))
        else $error("clamp pin hand-over wrong");

    blank_pin_a: assert property ( // [R10] [R16]
        out_ctl_ff[OUT_BL_OE_BIT] |=> !PIN_OE_N_O[PIN_BL] &&
        PIN_OUT_O[PIN_BL] ==
        ($past(BLANK_I) ^ $past(out_ctl_ff[OUT_BL_INV_BIT])))
        else $error("blanking pin hand-over wrong");

    horiz_inv_a: assert property ( // [R13]
        out_ctl_ff[OUT_H_OE_BIT] && !isg_w && h_mode_w == 2'b00 |=>
        PIN_OUT_O[PIN_H] ==
        ($past(ihi_ff) ^ $past(out_ctl_ff[OUT_H_INV_BIT])))
        else $error("horizontal output polarity wrong");

    vert_inv_a: assert property ( // [R14]
        out_ctl_ff[OUT_V_OE_BIT] && !isg_w && v_mode_w == 2'b00 |=>
        PIN_OUT_O[PIN_V] ==
        ($past(ivi_ff) ^ $past(out_ctl_ff[OUT_V_INV_BIT])))
        else $error("vertical output polarity wrong");

    bank_write_a: assert property ( // [R06] [R17]
        src_write_s |=>
        src_sel_ff == $past(PWDATA_I[REG_W-1:0]) &&
        TIMER_BANK_SELECT_O == $past(PWDATA_I[SRC_BANK_BIT]))
        else $error("source select write lost");

    horiz_2fh_a: assert property ( // [R20]
        out_ctl_ff[OUT_H_OE_BIT] && !isg_w && h_mode_w == 2'b01 |=>
        PIN_OUT_O[PIN_H] ==
        ($past(HORIZ_2FH_MOD_I) ^ $past(out_ctl_ff[OUT_H_INV_BIT])))
        else $error("modified horizontal source not routed");

    horiz_clamp_a: assert property ( // [R24]
        out_ctl_ff[OUT_H_OE_BIT] && !isg_w && h_mode_w == 2'b10 |=>
        PIN_OUT_O[PIN_H] ==
        ($past(CLAMP_VARIANT_I[0]) ^ $past(out_ctl_ff[OUT_H_INV_BIT])))
        else $error("clamp-derived horizontal source wrong");

    vert_variant_a: assert property ( // [R21]
        out_ctl_ff[OUT_V_OE_BIT] && !isg_w && v_mode_w == 2'b11 |=>
        PIN_OUT_O[PIN_V] ==
        ($past(VERT_VARIANT_I[3]) ^ $past(out_ctl_ff[OUT_V_INV_BIT])))
        else $error("vertical variant not routed");

    clamp_reserved_a: assert property ( // [R22] [R25]
        out_ctl_ff[OUT_CL_OE_BIT] && !isg_w && cl_mode_w == 2'b11 |=>
        PIN_OUT_O[PIN_CL] == $past(out_ctl_ff[OUT_CL_INV_BIT]))
        else $error("reserved clamp code not low");

    comp_mode_a: assert property ( // [R23]
        (in_mode_w == 2'b10) |=>
        CONDITIONED_VERT_IN_O == $past(SEPARATED_VERT_I) &&
        CONDITIONED_HORIZ_IN_O ==
        ($past(HORIZ_SYNC_IN_PIN_I) ^ $past(in_ctl_ff[IN_H_INV_BIT])))
        else $error("composite mode sources wrong");

endmodule : sync_signal_polarity_routing

// ### tb/sync_source_model.sv
// Behavioural model of the external sync sources feeding the sync pins
`timescale 1ns/1ps

module sync_source_model (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [4:0] level_i,
    output logic [4:0] pins_o
);
    // ========================================================================
    // Pin drive
    // Levels change only after a clock edge, like a real timing source
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pins_o <= 5'h00;
        end else begin
            pins_o <= level_i;
        end
    end
endmodule : sync_source_model

// ### tb/sync_signal_polarity_routing_tb_top.sv
// Self-checking testbench for the sync polarity and routing block
`timescale 1ns/1ps

module sync_signal_polarity_routing_tb_top;
    import sync_route_pkg::*;
    logic clk, rst_n, stby, psel, penable, pwrite, pin_req;
    logic [7:0] paddr;
    logic [31:0] pwdata, seed;
    logic [4:0] lvl;
    logic sep_v, h2f, blank, gen_h, gen_v, host_iface_enable;
    logic [3:1] vvar;
    logic [3:0] clv, alt_out, alt_oe_n;
    logic [7:0] ic, oc, sc;
    wire logic pready, pslverr, ch, cv, conn, bsel, bacc;
    wire logic [31:0] prdata;
    wire logic [4:0] pins;
    wire logic [3:0] pin_out, pin_oe_n;
    logic [33:0] bus_q[$];
    logic [12:0] pin_q[$];
    int num_errors, total_checks;

    // ========================================================================
    // Clock, partner and design
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    sync_source_model sync_source_model_inst (.clk_i(clk), .arst_n_i(rst_n),
        .level_i(lvl), .pins_o(pins));

    sync_signal_polarity_routing sync_signal_polarity_routing_inst (
        .CLK_SYS_I(clk), .ARST_N_I(rst_n), .STANDBY_I(stby),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf),
        .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr),
        .HORIZ_SYNC_IN_PIN_I(pins[0]), .COMPOSITE_SYNC_IN_PIN_I(pins[1]),
        .VERT_SYNC_IN_PIN_I(pins[2]), .SPARE_HORIZ_IN_PIN_I(pins[3]),
        .SPARE_VERT_IN_PIN_I(pins[4]), .SEPARATED_VERT_I(sep_v),
        .HORIZ_2FH_MOD_I(h2f), .VERT_VARIANT_I(vvar),
        .GENERATED_HORIZ_SYNC_I(gen_h), .GENERATED_VERT_SYNC_I(gen_v),
        .CLAMP_VARIANT_I(clv), .BLANK_I(blank),
        .HOST_IFACE_ENABLE_I(host_iface_enable), .ALT_OUT_I(alt_out),
        .ALT_OE_N_I(alt_oe_n), .PIN_OUT_O(pin_out), .PIN_OE_N_O(pin_oe_n),
        .CONDITIONED_HORIZ_IN_O(ch), .CONDITIONED_VERT_IN_O(cv),
        .SYNC_TIMER_CONNECT_O(conn), .TIMER_BANK_SELECT_O(bsel),
        .TIMER_BANK_ACCESS_O(bacc));

    // ========================================================================
    // Compare tasks and reference
    task automatic chk_bus(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: bus got %h expected %h", $time, got, exp);
        end
    endtask : chk_bus

    task automatic chk_pins(input logic [12:0] got, input logic [12:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: pins got %h expected %h", $time, got, exp);
        end
    endtask : chk_pins

    function automatic logic [12:0] pins_exp();
        logic conditioned_horiz_in, conditioned_vert_in, internal_horiz_out, internal_vert_out, internal_clamp_out;
        logic [3:0] s, en, po, oe;
        case (ic[7:6])
            2'd0: {conditioned_horiz_in, conditioned_vert_in} = {lvl[3] ^ ic[3], lvl[4] ^ ic[2]};
            2'd1: {conditioned_horiz_in, conditioned_vert_in} = {lvl[1] ^ ic[1], sep_v};
            2'd2: {conditioned_horiz_in, conditioned_vert_in} = {lvl[0] ^ ic[1], sep_v};
            default: {conditioned_horiz_in, conditioned_vert_in} = {lvl[0] ^ ic[1], lvl[2] ^ ic[0]};
        endcase
        if (sc[6]) begin
            internal_horiz_out = (sc[5:4] == 2'd0) & gen_h;
            internal_vert_out = (sc[3:2] == 2'd0) & gen_v;
            internal_clamp_out = (sc[1:0] == 2'd0) & clv[3];
        end else begin
            internal_horiz_out = (sc[5:4] == 2'd0) ? conditioned_horiz_in : (sc[5:4] == 2'd1) ? h2f :
                  (sc[5:4] == 2'd2) ? clv[0] : 1'b0;
            internal_vert_out = (sc[3:2] == 2'd0) ? conditioned_vert_in : vvar[sc[3:2]];
            internal_clamp_out = (sc[1:0] == 2'd3) ? 1'b0 : clv[sc[1:0]];
        end
        s = {blank ^ oc[0], internal_clamp_out ^ oc[1], internal_vert_out ^ oc[2], internal_horiz_out ^ oc[3]};
        en = {oc[4], oc[5], oc[6], oc[7]};
        for (int k = 0; k < 4; k++) begin
            po[k] = en[k] ? s[k] : alt_out[k];
            oe[k] = en[k] ? 1'b0 : alt_oe_n[k];
        end
        return {po, oe, conditioned_horiz_in, conditioned_vert_in, ic[5], sc[7], ~host_iface_enable};
    endfunction : pins_exp

    // ========================================================================
    // Drivers
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic err);
        @(posedge clk);
        bus_q.push_back({~wr, err, wr ? 32'h0 : d});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic check_pins();
        @(posedge clk);
        pin_q.push_back(pins_exp());
        pin_req <= 1'b1;
        @(posedge clk);
        pin_req <= 1'b0;
    endtask : check_pins

    // ========================================================================
    // Monitor: settles each result against the oldest note
    always @(posedge clk) begin
        logic [33:0] e;
        if (psel && penable && pready === 1'b1 && bus_q.size() > 0) begin
            e = bus_q.pop_front();
            chk_bus({pslverr, e[33] ? prdata : 32'h0}, e[32:0]);
        end
        if (pin_req && pin_q.size() > 0) begin
            chk_pins({pin_out, pin_oe_n, ch, cv, conn, bsel, bacc},
                     pin_q.pop_front());
        end
    end

    task automatic final_report();
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // Generous ceiling: the sequence needs roughly 3600 cycles
    initial begin
        #200000;
        num_errors++;
        final_report();
    end

    // ========================================================================
    // Main sequence
    initial begin
        {rst_n, stby, psel, penable, pwrite, pin_req} = 6'h00;
        {paddr, pwdata, lvl, sep_v, h2f, blank, gen_h, gen_v} = '0;
        {host_iface_enable, vvar, clv, alt_out, ic, oc, sc} = '0;
        alt_oe_n = 4'hf;
        num_errors = 0;
        total_checks = 0;
        seed = $urandom(32'h15b5);
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, OFS_IN_CTL, 32'h0, 1'b0);
        apb(1'b0, OFS_OUT_CTL, 32'h0, 1'b0);
        apb(1'b0, OFS_SRC_SEL, 32'h0, 1'b0);
        apb(1'b0, 8'h10, 32'h0, 1'b1);
        apb(1'b1, OFS_STATUS, 32'h3, 1'b1);
        check_pins();
        // Walk every source select code once, other fields random
        for (int i = 0; i < 128; i++) begin
            @(posedge clk);
            ic = 8'($urandom);
            oc = 8'($urandom);
            sc = {1'($urandom), 7'(i)};
            lvl <= 5'($urandom);
            {sep_v, h2f, blank, gen_h, gen_v, host_iface_enable} <= 6'($urandom);
            {vvar, clv} <= 7'($urandom);
            {alt_out, alt_oe_n} <= 8'($urandom);
            apb(1'b1, OFS_IN_CTL, {24'h0, ic}, 1'b0);
            apb(1'b1, OFS_OUT_CTL, {24'h0, oc}, 1'b0);
            apb(1'b1, OFS_SRC_SEL, {24'h0, sc}, 1'b0);
            repeat (3) @(posedge clk);
            check_pins();
            check_pins();
            check_pins();
            apb(1'b0, OFS_OUT_CTL, {24'h0, oc}, 1'b0);
            apb(1'b0, OFS_SRC_SEL, {24'h0, sc}, 1'b0);
            apb(1'b0, OFS_STATUS,
                {30'h0, 2'(pins_exp() >> 3)}, 1'b0);
        end
        @(posedge clk);
        stby <= 1'b1;
        repeat (2) @(posedge clk);
        stby <= 1'b0;
        {ic, oc, sc} = '0;
        apb(1'b0, OFS_OUT_CTL, 32'h0, 1'b0);
        apb(1'b0, OFS_SRC_SEL, 32'h0, 1'b0);
        repeat (3) @(posedge clk);
        check_pins();
        repeat (2) @(posedge clk);
        final_report();
    end
endmodule : sync_signal_polarity_routing_tb_top
